// file: src/rwi_pkg.sv
// Purpose: Constants and types for the wake-up and reset state block
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses below
// Notes:   Register offsets are byte addresses
// Operation
// (R1) Interrupt wake with a global enable set loads PC with 0008h or 0018h.
// (R2) That wake copies the current PC into the upper, high, low stack top.
// (R3) That wake advances the stack pointer to the next stack location.
// (R4) Interrupt or watchdog wake leaves a cause bit set in the flag register.
// (R5) Port A bits 6 and 7 exist only when oscillator mode frees them.
// (R6) Unimplemented register bits always read as zero.
// (R7) Bits unchanged by an event keep contents; unknown bits may hold anything.
package rwi_pkg;
   localparam int          PC_W         = 21;
   localparam int          SP_W         = 5;
   localparam int          AW           = 8;
   localparam logic [20:0] VEC_HIGH     = 21'h00008;
   localparam logic [20:0] VEC_LOW      = 21'h00018;
   localparam logic [20:0] PC_STEP      = 21'h00002;
   localparam logic [20:0] PC_RST       = 21'h00000;
   localparam logic [4:0]  SP_RST       = 5'h00;
   localparam logic [4:0]  SP_ONE       = 5'h01;
   localparam logic [7:0]  TRIS_RST     = 8'hFF;
   localparam logic [7:0]  MASK_ALL     = 8'hFF;
   localparam logic [7:0]  MASK_NO67    = 8'h3F;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_PC       = 8'h04;
   localparam logic [7:0]  OFS_TOS      = 8'h08;
   localparam logic [7:0]  OFS_SP       = 8'h0C;
   localparam logic [7:0]  OFS_FLAGS    = 8'h10;
   localparam logic [7:0]  OFS_PORT     = 8'h14;
   localparam logic [7:0]  OFS_LAT      = 8'h18;
   localparam logic [7:0]  OFS_TRIS     = 8'h1C;
   localparam logic [7:0]  OFS_ISTAT    = 8'h20;
   localparam logic [7:0]  OFS_ICLR     = 8'h24;
   localparam logic [7:0]  OFS_IEN      = 8'h28;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam int          FLAG_HIGH    = 0;
   localparam int          FLAG_LOW     = 1;
   localparam int          FLAG_WDT     = 2;
   localparam int          EV_VECTOR    = 0;
   localparam int          EV_RESUME    = 1;
   localparam int          EV_RESET     = 2;

   typedef struct packed {
      logic osc_frees_67;
      logic low_prio_global_int_enable;
      logic high_prio_global_int_enable;
   } rwi_ctrl_t;

   typedef struct packed {
      logic [4:0] stack_top_upper_byte;
      logic [7:0] stack_top_high_byte;
      logic [7:0] stack_top_low_byte;
   } rwi_tos_t;
endpackage

// file: src/rwi_core.sv
// Purpose: Program counter, stack top and flag handling on wake-up and reset
// Assumes: Event inputs are one-cycle pulses synchronous to core_clk
// Notes:   rst acts as power-on reset; bor_reset and soft_reset are pulses
`timescale 1ns/10ps
`default_nettype none
module rwi_core
   import rwi_pkg::*;
(
   input  wire  logic         core_clk,
   input  wire  logic         rst,
   input  wire  logic         int_wake,
   input  wire  logic         int_wake_high,
   input  wire  logic         wdt_wake,
   input  wire  logic         bor_reset,
   input  wire  logic         soft_reset,
   input  wire  logic [7:0]   port_a_pins_in,
   output logic [7:0]         port_a_out,
   output logic [7:0]         port_a_oe,
   output logic [PC_W-1:0]    pc_out,
   output logic               irq,
   input  wire  logic         s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire  logic [AW-1:0] s_axi_awaddr,
   input  wire  logic         s_axi_wvalid,
   output logic               s_axi_wready,
   input  wire  logic [31:0]  s_axi_wdata,
   input  wire  logic [3:0]   s_axi_wstrb,
   output logic               s_axi_bvalid,
   input  wire  logic         s_axi_bready,
   output logic [1:0]         s_axi_bresp,
   input  wire  logic         s_axi_arvalid,
   output logic               s_axi_arready,
   input  wire  logic [AW-1:0] s_axi_araddr,
   output logic               s_axi_rvalid,
   input  wire  logic         s_axi_rready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp
);
   rwi_ctrl_t         ctrl;
   rwi_tos_t          tos;
   logic [PC_W-1:0]   pc;
   logic [SP_W-1:0]   return_stack_pointer;
   logic [7:0]        peripheral_int_flag_regs;
   logic [7:0]        port_a_output_latch;
   logic [7:0]        port_a_direction;
   logic [7:0]        port_mask;
   logic [2:0]        irq_status;
   logic [2:0]        irq_enable;
   logic              aw_hold;
   logic              w_hold;
   logic [AW-1:0]     aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_wr;
   logic              wr_ok;
   logic              gie_any;
   logic              vec_wake;
   logic [31:0]       next_rdata;
   logic              next_rok;

   assign gie_any  = ctrl.high_prio_global_int_enable | ctrl.low_prio_global_int_enable;
   assign vec_wake = int_wake & gie_any & ~soft_reset & ~bor_reset;
   assign do_wr    = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_ok    = do_wr & (w_strb != 4'h0);
   assign port_mask = ctrl.osc_frees_67 ? MASK_ALL : MASK_NO67; // R5

   // Write address and data captured independently
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aw_hold <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         w_hold <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_wr) begin
         w_hold <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == OFS_CTRL || aw_addr == OFS_PC || aw_addr == OFS_FLAGS ||
             aw_addr == OFS_LAT || aw_addr == OFS_TRIS || aw_addr == OFS_ICLR ||
             aw_addr == OFS_IEN) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= '0;
      end else if (wr_ok && aw_addr == OFS_CTRL) begin
         ctrl <= w_data[2:0];
      end
   end

   // PC: resets, vectored wake, resume wake, software write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc <= PC_RST;
      end else if (soft_reset || bor_reset) begin
         pc <= PC_RST;
      end else if (vec_wake) begin
         pc <= int_wake_high ? VEC_HIGH : VEC_LOW; // R1
      end else if (int_wake || wdt_wake) begin
         pc <= PC_W'(pc + PC_STEP);
      end else if (wr_ok && aw_addr == OFS_PC) begin
         pc <= w_data[PC_W-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tos <= '0;
      end else if (soft_reset || bor_reset) begin
         tos <= '0;
      end else if (vec_wake) begin
         tos <= pc; // R2
      end
   end

   // Pointer survives soft resets, cleared by brown-out
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         return_stack_pointer <= SP_RST;
      end else if (bor_reset) begin
         return_stack_pointer <= SP_RST;
      end else if (vec_wake) begin
         return_stack_pointer <= SP_W'(return_stack_pointer + SP_ONE); // R3
      end
   end

   // Cause flags: write one to clear, a new cause wins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         peripheral_int_flag_regs <= '0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if ((i == FLAG_HIGH && int_wake && int_wake_high) ||
                (i == FLAG_LOW && int_wake && !int_wake_high) ||
                (i == FLAG_WDT && wdt_wake)) begin
               peripheral_int_flag_regs[i] <= 1'b1; // R4
            end else if (wr_ok && aw_addr == OFS_FLAGS && w_data[i]) begin
               peripheral_int_flag_regs[i] <= 1'b0;
            end
         end
      end
   end

   // Port A latch and direction keep contents through soft resets
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port_a_output_latch <= '0;
         port_a_direction    <= TRIS_RST;
      end else if (wr_ok && aw_addr == OFS_LAT) begin
         port_a_output_latch <= w_data[7:0] & port_mask; // R5 R7
      end else if (wr_ok && aw_addr == OFS_TRIS) begin
         port_a_direction <= w_data[7:0] | ~port_mask;
      end
   end

   assign port_a_out = port_a_output_latch & port_mask; // R5
   assign port_a_oe  = ~port_a_direction & port_mask;
   assign pc_out     = pc;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if ((i == EV_VECTOR && vec_wake) ||
                (i == EV_RESUME && (wdt_wake || (int_wake && !gie_any))) ||
                (i == EV_RESET && (soft_reset || bor_reset))) begin
               irq_status[i] <= 1'b1;
            end else if (wr_ok && aw_addr == OFS_ICLR && w_data[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_enable <= '0;
      end else if (wr_ok && aw_addr == OFS_IEN) begin
         irq_enable <= w_data[2:0];
      end
   end

   assign irq = |(irq_status & irq_enable);

   // Read decode; every bit not listed reads zero
   always_comb begin
      next_rdata = '0;
      next_rok   = 1'b1;
      if (s_axi_araddr == OFS_CTRL) begin
         next_rdata[2:0] = ctrl;
      end else if (s_axi_araddr == OFS_PC) begin
         next_rdata[PC_W-1:0] = pc;
      end else if (s_axi_araddr == OFS_TOS) begin
         next_rdata[PC_W-1:0] = tos;
      end else if (s_axi_araddr == OFS_SP) begin
         next_rdata[SP_W-1:0] = return_stack_pointer; // R6
      end else if (s_axi_araddr == OFS_FLAGS) begin
         next_rdata[7:0] = peripheral_int_flag_regs;
      end else if (s_axi_araddr == OFS_PORT) begin
         next_rdata[7:0] = port_a_pins_in & port_mask; // R5
      end else if (s_axi_araddr == OFS_LAT) begin
         next_rdata[7:0] = port_a_output_latch & port_mask;
      end else if (s_axi_araddr == OFS_TRIS) begin
         next_rdata[7:0] = port_a_direction & port_mask;
      end else if (s_axi_araddr == OFS_ISTAT) begin
         next_rdata[2:0] = irq_status;
      end else if (s_axi_araddr == OFS_IEN) begin
         next_rdata[2:0] = irq_enable;
      end else begin
         next_rok = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   property p_vector;
      @(posedge core_clk) disable iff (rst)
      vec_wake |=> pc == ($past(int_wake_high) ? VEC_HIGH : VEC_LOW);
   endproperty
   a_vector: assert property (p_vector) else $error("wake vector wrong"); // R1

   property p_tos;
      @(posedge core_clk) disable iff (rst)
      vec_wake |=> tos == $past(pc);
   endproperty
   a_tos: assert property (p_tos) else $error("stack top not loaded"); // R2

   property p_sp;
      @(posedge core_clk) disable iff (rst)
      vec_wake |=> return_stack_pointer == SP_W'($past(return_stack_pointer) + SP_ONE);
   endproperty
   a_sp: assert property (p_sp) else $error("stack pointer not advanced"); // R3

   property p_flag;
      @(posedge core_clk) disable iff (rst)
      (int_wake || wdt_wake) |=> peripheral_int_flag_regs != 8'h00;
   endproperty
   a_flag: assert property (p_flag) else $error("no wake cause flag"); // R4

   property p_port67;
      @(posedge core_clk) disable iff (rst)
      !ctrl.osc_frees_67 |-> (port_a_out[7:6] == 2'h0 && port_a_oe[7:6] == 2'h0);
   endproperty
   a_port67: assert property (p_port67) else $error("port bits 6 7 active"); // R5

   property p_unimpl;
      @(posedge core_clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[31:PC_W] == '0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused bits read nonzero"); // R6

   property p_keep;
      @(posedge core_clk) disable iff (rst)
      (soft_reset && !bor_reset && !do_wr) |=> port_a_output_latch == $past(port_a_output_latch)
         && return_stack_pointer == $past(return_stack_pointer);
   endproperty
   a_keep: assert property (p_keep) else $error("state lost on soft reset"); // R7

   property p_irq;
      @(posedge core_clk) disable iff (rst)
      (vec_wake && irq_enable[EV_VECTOR] && !(wr_ok && aw_addr == OFS_IEN)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised"); // R4

   c_vec_high: cover property (@(posedge core_clk) disable iff (rst) vec_wake && int_wake_high);
   c_wdt: cover property (@(posedge core_clk) disable iff (rst) wdt_wake);
   c_soft: cover property (@(posedge core_clk) disable iff (rst) soft_reset ##1 vec_wake);
endmodule // rwi_core
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the wake-up and reset state block
// Assumes: Inputs change by NBA on rising edges, outputs sampled on falling
// Notes:   Read data is checked by a monitor against a queue of expectations
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import rwi_pkg::*;
();
   logic            core_clk = 1'b0;
   logic            rst = 1'b1;
   logic [4:0]      ev = 5'h00;
   logic [7:0]      pins = 8'h00;
   logic [7:0]      pa_out;
   logic [7:0]      pa_oe;
   logic [PC_W-1:0] pc;
   logic            irq;
   logic            awvalid = 1'b0;
   logic            awready;
   logic [AW-1:0]   awaddr = 8'h00;
   logic            wvalid = 1'b0;
   logic            wready;
   logic [31:0]     wdata = 32'h0;
   logic [3:0]      wstrb = 4'hF;
   logic            bvalid;
   logic            bready = 1'b0;
   logic [1:0]      bresp;
   logic            arvalid = 1'b0;
   logic            arready;
   logic [AW-1:0]   araddr = 8'h00;
   logic            rvalid;
   logic            rready = 1'b0;
   logic [31:0]     rdata;
   logic [1:0]      rresp;
   logic [33:0]     exp_q[$];
   logic [31:0]     seed = 32'h00000039;
   logic [20:0]     p;
   logic [7:0]      pv;
   int              n_mismatch = 0;
   int              total_checks = 0;

   always #12.5 core_clk = ~core_clk;

   rwi_core dut (.core_clk(core_clk), .rst(rst), .int_wake(ev[4]), .int_wake_high(ev[3]),
      .wdt_wake(ev[2]), .bor_reset(ev[1]), .soft_reset(ev[0]), .port_a_pins_in(pins),
      .port_a_out(pa_out), .port_a_oe(pa_oe), .pc_out(pc), .irq(irq),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic report_and_stop();
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic timed_out();
      n_mismatch++;
      report_and_stop();
   endtask

   // Write: address and data offered together, bready held until bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha;
      logic hw;
      logic done;
      int   i;
      @(posedge core_clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge core_clk);
         ha   = awvalid && awready;
         hw   = wvalid && wready;
         done = bvalid && bready;
         if (done)
            check({32'h0, bresp}, {32'h0, er});
         @(posedge core_clk);
         if (ha)
            awvalid <= 1'b0;
         if (hw)
            wvalid <= 1'b0;
         if (done) begin
            bready <= 1'b0;
            break;
         end
      end
      if (i == 50)
         timed_out();
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ha;
      logic done;
      int   i;
      exp_q.push_back({ed, er});
      @(posedge core_clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge core_clk);
         ha   = arvalid && arready;
         done = rvalid && rready;
         @(posedge core_clk);
         if (ha)
            arvalid <= 1'b0;
         if (done) begin
            rready <= 1'b0;
            break;
         end
      end
      if (i == 50)
         timed_out();
   endtask

   // Order: {int_wake, int_wake_high, wdt_wake, bor_reset, soft_reset}
   task automatic pulse(input logic [4:0] e);
      @(posedge core_clk);
      ev <= e;
      @(posedge core_clk);
      ev <= 5'h00;
      @(negedge core_clk);
   endtask

   always @(negedge core_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (exp_q.size() > 0)
            check({rdata, rresp}, exp_q.pop_front());
         else
            check({rdata, rresp}, 34'h3FFFFFFFF);
      end
   end

   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      check({13'h0, pc}, {13'h0, PC_RST});
      check({26'h0, pa_oe}, 34'h0);
      axi_rd(OFS_TRIS, 32'h3F, RESP_OKAY);
      axi_rd(OFS_SP, 32'h0, RESP_OKAY);
      axi_rd(8'h2C, 32'h0, RESP_SLVERR);
      axi_wr(OFS_CTRL, 32'hFFFFFFFF, RESP_OKAY);
      axi_rd(OFS_CTRL, 32'h7, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
      seed = xs(seed);
      p = seed[20:0] & 21'h1FFFFE;
      axi_wr(OFS_PC, {11'h0, p}, RESP_OKAY);
      axi_wr(OFS_IEN, 32'h1, RESP_OKAY);
      pulse(5'b11000);
      check({13'h0, pc}, {13'h0, VEC_HIGH});
      check({33'h0, irq}, 34'h1);
      axi_rd(OFS_TOS, {11'h0, p}, RESP_OKAY);
      axi_rd(OFS_SP, 32'h1, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'h1, RESP_OKAY);
      pulse(5'b10000);
      check({13'h0, pc}, {13'h0, VEC_LOW});
      axi_rd(OFS_TOS, {11'h0, VEC_HIGH}, RESP_OKAY);
      axi_rd(OFS_SP, 32'h2, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'h3, RESP_OKAY);
      axi_wr(OFS_IEN, 32'h2, RESP_OKAY);
      check({33'h0, irq}, 34'h0);
      axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
      pulse(5'b00100);
      check({13'h0, pc}, {13'h0, VEC_LOW + PC_STEP});
      wstrb <= 4'h0;
      axi_wr(OFS_PC, 32'h0, RESP_OKAY);
      wstrb <= 4'hF;
      check({13'h0, pc}, {13'h0, VEC_LOW + PC_STEP});
      axi_rd(OFS_TOS, {11'h0, VEC_HIGH}, RESP_OKAY);
      axi_rd(OFS_SP, 32'h2, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'h7, RESP_OKAY);
      check({33'h0, irq}, 34'h1);
      axi_rd(OFS_ISTAT, 32'h3, RESP_OKAY);
      axi_wr(OFS_ICLR, 32'h2, RESP_OKAY);
      check({33'h0, irq}, 34'h0);
      axi_rd(OFS_ISTAT, 32'h1, RESP_OKAY);
      axi_wr(OFS_FLAGS, 32'h7, RESP_OKAY);
      axi_rd(OFS_FLAGS, 32'h0, RESP_OKAY);
      axi_wr(OFS_TOS, 32'h0, RESP_SLVERR);
      axi_rd(OFS_TOS, {11'h0, VEC_HIGH}, RESP_OKAY);
      seed = xs(seed);
      pv = seed[7:0];
      pins <= pv;
      axi_wr(OFS_LAT, 32'hFF, RESP_OKAY);
      axi_rd(OFS_LAT, 32'h3F, RESP_OKAY);
      check({26'h0, pa_out}, 34'h3F);
      axi_wr(OFS_TRIS, 32'h0, RESP_OKAY);
      check({26'h0, pa_oe}, 34'h3F);
      axi_rd(OFS_PORT, {24'h0, pv & 8'h3F}, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h4, RESP_OKAY);
      axi_wr(OFS_LAT, 32'hFF, RESP_OKAY);
      axi_wr(OFS_TRIS, 32'h0, RESP_OKAY);
      check({26'h0, pa_out}, 34'hFF);
      check({26'h0, pa_oe}, 34'hFF);
      axi_rd(OFS_PORT, {24'h0, pv}, RESP_OKAY);
      pulse(5'b00001);
      check({13'h0, pc}, {13'h0, PC_RST});
      axi_rd(OFS_TOS, 32'h0, RESP_OKAY);
      axi_rd(OFS_SP, 32'h2, RESP_OKAY);
      axi_wr(OFS_IEN, 32'h4, RESP_OKAY);
      check({33'h0, irq}, 34'h1);
      pulse(5'b00010);
      axi_rd(OFS_SP, 32'h0, RESP_OKAY);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
